// ### pif_top.sv
// Peripheral interrupt flag block with an AXI4-Lite register slave.
//
// Behaviour
// - Flags set on their event regardless of enable bits or global enable.
// - Absent serial transmitter and receiver bits read zero.
// - Sync serial flag sets on transfer done, stays until software clears.
// - Capture mode: first unit flag sets on timer capture, sticky.
// - Compare mode: flag sets on match, software clears; unused in pulse mode.
// - Period timer flag sets on count equal to limit, sticky.
// - Wide timer overflow flag sets on overflow, stays until written zero.
// - Receive flag is read-only and follows the full receive buffer.
// - Transmit flag is read-only and follows the empty transmit buffer.
// - With parallel port, top flag sets on each external read or write.
// - Second flag register holds the second capture/compare unit flag.
// - Second enable register holds the second unit interrupt enable.
// - Each flag of flag register one has an enable at the same position in enable one.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "pif_defines.svh"
module pif_top import pif_pkg::*; #(
    parameter int HAS_USART   = 1,
    parameter int HAS_PSP     = 1,
    parameter int HAS_CAPCMP2 = 1
) (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [`PIF_ADDR_W-1:0]  awaddr,
    input  wire logic [2:0]              awprot,
    input  wire logic                    awvalid,
    output logic                         awready,
    input  wire logic [31:0]             wdata,
    input  wire logic [3:0]              wstrb,
    input  wire logic                    wvalid,
    output logic                         wready,
    output logic [1:0]                   bresp,
    output logic                         bvalid,
    input  wire logic                    bready,
    input  wire logic [`PIF_ADDR_W-1:0]  araddr,
    input  wire logic [2:0]              arprot,
    input  wire logic                    arvalid,
    output logic                         arready,
    output logic [31:0]                  rdata,
    output logic [1:0]                   rresp,
    output logic                         rvalid,
    input  wire logic                    rready,
    input  wire logic                    sync_serial_done,
    input  wire logic                    capcmp_one_event,
    input  wire pif_ccp_mode_t           capcmp_one_mode,
    input  wire logic                    period_timer_match,
    input  wire logic                    wide_timer_overflow,
    input  wire logic                    serial_receive_full,
    input  wire logic                    serial_transmit_empty,
    input  wire logic                    parallel_port_done,
    input  wire logic                    capcmp_two_event,
    input  wire pif_ccp_mode_t           capcmp_two_mode,
    output logic                         irq
);
    if (HAS_USART < 0 || HAS_USART > 1 || HAS_PSP < 0 || HAS_PSP > 1 ||
        HAS_CAPCMP2 < 0 || HAS_CAPCMP2 > 1) begin : g_param_check
        $error("Variant parameters must be 0 or 1.");
    end

    localparam logic [7:0] ENAB1_M = (HAS_USART != 0) ? 8'hff : 8'hcf;
    localparam logic [7:0] ENAB2_M = (HAS_CAPCMP2 != 0) ?
        (8'h01 << `PIF_BIT_CAPCMP2) : 8'h00;

    function automatic pif_sel_t decode(input logic [`PIF_ADDR_W-1:0] a);
        logic [`PIF_IDX_W-1:0] idx;
        idx = a[`PIF_ADDR_W-1:2];
        case (idx)
            `PIF_IDX_CONTROL:   decode = PIF_SEL_CTRL;
            `PIF_IDX_FLAGS_ONE: decode = PIF_SEL_FL1;
            `PIF_IDX_FLAGS_TWO: decode = PIF_SEL_FL2;
            `PIF_IDX_ENAB_ONE:  decode = PIF_SEL_EN1;
            `PIF_IDX_ENAB_TWO:  decode = PIF_SEL_EN2;
            default:            decode = PIF_SEL_NONE;
        endcase
    endfunction : decode

    function automatic logic [7:0] bit_at(input logic on, input int pos);
        bit_at = on ? (8'h01 << pos) : 8'h00;
    endfunction : bit_at

    pif_flag_if fl ();

    pif_flag_bank #(
        .HAS_USART (HAS_USART)
    ) u_bank (
        .aclk    (aclk),
        .aresetn (aresetn),
        .fl      (fl)
    );

    pif_top_state_t s_q;
    pif_top_state_t s_d;
    pif_sel_t       wsel;
    pif_sel_t       rsel;
    logic           commit;
    logic           capcmp_one_live;
    logic           capcmp_two_live;

    always_comb begin
        capcmp_one_live = capcmp_one_event &&
            (capcmp_one_mode == PIF_MODE_CAPTURE ||
             capcmp_one_mode == PIF_MODE_COMPARE);
        capcmp_two_live = (HAS_CAPCMP2 != 0) && capcmp_two_event &&
            (capcmp_two_mode == PIF_MODE_CAPTURE ||
             capcmp_two_mode == PIF_MODE_COMPARE);
        fl.set_one = bit_at(sync_serial_done, `PIF_BIT_SYNC)
            | bit_at(capcmp_one_live, `PIF_BIT_CAPCMP1)
            | bit_at(period_timer_match, `PIF_BIT_PERIOD)
            | bit_at(wide_timer_overflow, `PIF_BIT_OVERFLOW)
            | bit_at((HAS_PSP != 0) && parallel_port_done,
                     `PIF_BIT_PARALLEL);
        fl.set_two = bit_at(capcmp_two_live, `PIF_BIT_CAPCMP2);
        fl.live_one = bit_at(serial_receive_full, `PIF_BIT_RECEIVE)
            | bit_at(serial_transmit_empty, `PIF_BIT_TRANSMIT);
    end

    always_comb begin
        s_d    = s_q;
        wsel   = decode(s_q.awaddr);
        rsel   = decode(araddr);
        commit = s_q.aw_have && s_q.w_have && !s_q.bvalid;

        fl.wdata  = s_q.wdata;
        fl.wr_one = commit && s_q.wstrb0 && wsel == PIF_SEL_FL1;
        fl.wr_two = commit && s_q.wstrb0 && wsel == PIF_SEL_FL2;

        if (awvalid && s_q.awready) begin
            s_d.awaddr  = awaddr;
            s_d.aw_have = 1'b1;
            s_d.awready = 1'b0;
        end else if (!s_q.aw_have) begin
            s_d.awready = 1'b1;
        end
        if (wvalid && s_q.wready) begin
            s_d.wdata  = wdata[7:0];
            s_d.wstrb0 = wstrb[0];
            s_d.w_have = 1'b1;
            s_d.wready = 1'b0;
        end else if (!s_q.w_have) begin
            s_d.wready = 1'b1;
        end

        if (commit) begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready  = 1'b1;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = (wsel == PIF_SEL_NONE) ?
                `PIF_RESP_SLVERR : `PIF_RESP_OKAY;
            if (s_q.wstrb0) begin
                case (wsel)
                    PIF_SEL_CTRL: s_d.control  =
                        bit_at(s_q.wdata[`PIF_BIT_GLOBAL], `PIF_BIT_GLOBAL);
                    PIF_SEL_EN1:  s_d.enab_one = s_q.wdata & ENAB1_M;
                    PIF_SEL_EN2:  s_d.enab_two = s_q.wdata & ENAB2_M;
                    default:      s_d.bresp    = s_q.bvalid ?
                        s_q.bresp : s_d.bresp;
                endcase
            end
        end else if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end

        if (arvalid && s_q.arready) begin
            s_d.arready = 1'b0;
            s_d.rvalid  = 1'b1;
            s_d.rresp   = `PIF_RESP_OKAY;
            case (rsel)
                PIF_SEL_CTRL: s_d.rdata = s_q.control;
                PIF_SEL_FL1:  s_d.rdata = fl.flags_one;
                PIF_SEL_FL2:  s_d.rdata = fl.flags_two;
                PIF_SEL_EN1:  s_d.rdata = s_q.enab_one;
                PIF_SEL_EN2:  s_d.rdata = s_q.enab_two;
                default: begin
                    s_d.rdata = 8'h00;
                    s_d.rresp = `PIF_RESP_SLVERR;
                end
            endcase
        end else if (s_q.rvalid && rready) begin
            s_d.rvalid  = 1'b0;
            s_d.arready = 1'b1;
        end else if (!s_q.rvalid) begin
            s_d.arready = 1'b1;
        end

        s_d.irq = s_q.control[`PIF_BIT_GLOBAL] &&
            (((fl.flags_one & s_q.enab_one) != 8'h00) ||
             ((fl.flags_two & s_q.enab_two) != 8'h00));
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign awready = s_q.awready;
    assign wready  = s_q.wready;
    assign bvalid  = s_q.bvalid;
    assign bresp   = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid  = s_q.rvalid;
    assign rresp   = s_q.rresp;
    assign rdata   = {24'h000000, s_q.rdata};
    assign irq     = s_q.irq;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence write_taken_s;
        s_q.aw_have && s_q.w_have && !s_q.bvalid;
    endsequence
    sequence write_answered_s;
        ##1 s_q.bvalid;
    endsequence

    sync_flag_a: assert property (sync_serial_done
        |=> fl.flags_one[`PIF_BIT_SYNC])
        else $error("Sync serial flag not set by its event.");
    capcmp_flag_a: assert property (capcmp_one_event &&
        capcmp_one_mode != PIF_MODE_PWM && capcmp_one_mode != PIF_MODE_OFF
        |=> fl.flags_one[`PIF_BIT_CAPCMP1])
        else $error("First unit flag not set on capture or match.");
    pulse_mode_a: assert property (capcmp_one_event &&
        capcmp_one_mode == PIF_MODE_PWM && !fl.flags_one[`PIF_BIT_CAPCMP1]
        && !fl.wr_one |=> !fl.flags_one[`PIF_BIT_CAPCMP1])
        else $error("First unit flag set in pulse-width mode.");
    period_flag_a: assert property (period_timer_match
        |=> fl.flags_one[`PIF_BIT_PERIOD])
        else $error("Period timer flag not set on match.");
    overflow_flag_a: assert property (wide_timer_overflow
        |=> fl.flags_one[`PIF_BIT_OVERFLOW])
        else $error("Overflow flag not set on overflow.");
    receive_flag_a: assert property (HAS_USART != 0 |=>
        fl.flags_one[`PIF_BIT_RECEIVE] == $past(serial_receive_full))
        else $error("Receive flag does not follow the buffer.");
    transmit_flag_a: assert property (HAS_USART != 0 |=>
        fl.flags_one[`PIF_BIT_TRANSMIT] == $past(serial_transmit_empty))
        else $error("Transmit flag does not follow the buffer.");
    absent_usart_a: assert property (HAS_USART == 0 |->
        fl.flags_one[`PIF_BIT_RECEIVE:`PIF_BIT_TRANSMIT] == 2'h0)
        else $error("Unimplemented flag bits read nonzero.");
    parallel_flag_a: assert property ((HAS_PSP != 0) &&
        parallel_port_done
        |=> fl.flags_one[`PIF_BIT_PARALLEL])
        else $error("Parallel port flag not set.");
    enable_gate_a: assert property (s_q.enab_one == 8'h00 &&
        s_q.enab_two == 8'h00 |=> !irq)
        else $error("Interrupt raised with all enables clear.");
    flag_unmasked_a: assert property ((HAS_CAPCMP2 != 0) &&
        capcmp_two_event && capcmp_two_mode == PIF_MODE_CAPTURE &&
        s_q.enab_two == 8'h00
        |=> fl.flags_two[`PIF_BIT_CAPCMP2])
        else $error("Flag set depended on its enable.");
    write_answer_a: assert property (write_taken_s |-> write_answered_s)
        else $error("Write response not given one cycle after commit.");
endmodule : pif_top

// ### pif_defines.svh
// Register indices, bit positions and response codes of the flag block.
`ifndef PIF_DEFINES_SVH
`define PIF_DEFINES_SVH

`define PIF_ADDR_W        12
`define PIF_DATA_W        8
`define PIF_IDX_W         10

`define PIF_IDX_CONTROL   10'h00b
`define PIF_IDX_FLAGS_ONE 10'h00c
`define PIF_IDX_FLAGS_TWO 10'h00d
`define PIF_IDX_ENAB_ONE  10'h08c
`define PIF_IDX_ENAB_TWO  10'h08d

`define PIF_BIT_GLOBAL    7
`define PIF_BIT_PARALLEL  7
`define PIF_BIT_RESERVED  6
`define PIF_BIT_RECEIVE   5
`define PIF_BIT_TRANSMIT  4
`define PIF_BIT_SYNC      3
`define PIF_BIT_CAPCMP1   2
`define PIF_BIT_PERIOD    1
`define PIF_BIT_OVERFLOW  0
`define PIF_BIT_CAPCMP2   0

`define PIF_RESET_BYTE    8'h00
`define PIF_RESP_OKAY     2'h0
`define PIF_RESP_SLVERR   2'h2

`endif

// ### pif_pkg.sv
// Types shared by the peripheral interrupt flag block.
package pif_pkg;
`include "pif_defines.svh"

    typedef enum logic [1:0] {
        PIF_MODE_CAPTURE = 2'h0,
        PIF_MODE_COMPARE = 2'h1,
        PIF_MODE_PWM     = 2'h3,
        PIF_MODE_OFF     = 2'h2
    } pif_ccp_mode_t;

    typedef enum logic [2:0] {
        PIF_SEL_NONE  = 3'h0,
        PIF_SEL_CTRL  = 3'h1,
        PIF_SEL_FL1   = 3'h3,
        PIF_SEL_FL2   = 3'h2,
        PIF_SEL_EN1   = 3'h6,
        PIF_SEL_EN2   = 3'h7
    } pif_sel_t;

    typedef struct packed {
        logic [7:0] one;
        logic [7:0] two;
    } pif_bank_state_t;

    typedef struct packed {
        logic [11:0] awaddr;
        logic        aw_have;
        logic [7:0]  wdata;
        logic        wstrb0;
        logic        w_have;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [7:0]  rdata;
        logic [1:0]  rresp;
        logic [7:0]  control;
        logic [7:0]  enab_one;
        logic [7:0]  enab_two;
        logic        irq;
    } pif_top_state_t;

endpackage : pif_pkg

// ### pif_flag_if.sv
// Carrier between the bus side and the flag bank.
`timescale 1ns/100ps
interface pif_flag_if;
    logic [7:0] set_one;
    logic [7:0] set_two;
    logic [7:0] live_one;
    logic [7:0] wdata;
    logic       wr_one;
    logic       wr_two;
    logic [7:0] flags_one;
    logic [7:0] flags_two;

    modport ctl (output set_one, set_two, live_one, wdata, wr_one, wr_two,
                 input  flags_one, flags_two);
    modport bank (input  set_one, set_two, live_one, wdata, wr_one, wr_two,
                  output flags_one, flags_two);
endinterface : pif_flag_if

// ### pif_flag_bank.sv
// Flag bank holding both peripheral flag registers.
`timescale 1ns/100ps
`include "pif_defines.svh"
module pif_flag_bank import pif_pkg::*; #(
    parameter int HAS_USART = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    pif_flag_if.bank fl
);
    localparam logic [7:0] LIVE_M = (HAS_USART != 0) ?
        ((8'h01 << `PIF_BIT_RECEIVE) | (8'h01 << `PIF_BIT_TRANSMIT)) : 8'h00;
    localparam logic [7:0] WR_M =
        ~((8'h01 << `PIF_BIT_RECEIVE) | (8'h01 << `PIF_BIT_TRANSMIT));

    pif_bank_state_t s_q;
    pif_bank_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (fl.wr_one) begin
            s_d.one = fl.wdata & WR_M;
        end
        s_d.one = (s_d.one | fl.set_one) & WR_M;
        s_d.one = s_d.one | (fl.live_one & LIVE_M);
        if (fl.wr_two) begin
            s_d.two = fl.wdata;
        end
        s_d.two = s_d.two | fl.set_two;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '{one: `PIF_RESET_BYTE, two: `PIF_RESET_BYTE};
        end else begin
            s_q <= s_d;
        end
    end

    assign fl.flags_one = s_q.one;
    assign fl.flags_two = s_q.two;

    set_wins_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (fl.wr_one && (fl.set_one & WR_M) != 8'h00)
        |=> ((fl.flags_one & $past(fl.set_one) & WR_M) == ($past(fl.set_one) & WR_M)))
        else $error("Flag set lost against a write of zero.");
    set_wins_two_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fl.set_two[`PIF_BIT_CAPCMP2] |=> fl.flags_two[`PIF_BIT_CAPCMP2])
        else $error("Second unit flag not set by its event.");
    sticky_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (fl.flags_one[`PIF_BIT_OVERFLOW] && !fl.wr_one)
        |=> fl.flags_one[`PIF_BIT_OVERFLOW])
        else $error("Overflow flag dropped without a write.");
endmodule : pif_flag_bank

// ### pif_periph_model.sv
// Model of the peripheral units that raise events toward the flag block.
`timescale 1ns/100ps
module pif_periph_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] req,
    input  wire logic       rx_lvl,
    input  wire logic       tx_lvl,
    output logic            sync_serial_done,
    output logic            capcmp_one_event,
    output logic            period_timer_match,
    output logic            wide_timer_overflow,
    output logic            serial_receive_full,
    output logic            serial_transmit_empty,
    output logic            parallel_port_done,
    output logic            capcmp_two_event
);
    logic [7:0] pulse_q;
    logic [1:0] lvl_q;

    // Events leave one cycle after their request bits and stay high as long as those bits are held.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_q <= 8'h00;
            lvl_q   <= 2'h0;
        end else begin
            pulse_q <= req;
            lvl_q   <= {rx_lvl, tx_lvl};
        end
    end

    assign parallel_port_done    = pulse_q[7];
    assign capcmp_two_event      = pulse_q[6];
    assign sync_serial_done      = pulse_q[3];
    assign capcmp_one_event      = pulse_q[2];
    assign period_timer_match    = pulse_q[1];
    assign wide_timer_overflow   = pulse_q[0];
    assign serial_receive_full   = lvl_q[1];
    assign serial_transmit_empty = lvl_q[0];
endmodule : pif_periph_model

// ### tb_top.sv
// Self-checking bench for the peripheral interrupt flag block.
`timescale 1ns/100ps
module tb_top import pif_pkg::*;;
    localparam logic [11:0] adr_ctl = 12'h02c, adr_fl1 = 12'h030;
    localparam logic [11:0] adr_fl2 = 12'h034, adr_en1 = 12'h230;
    localparam logic [11:0] adr_en2 = 12'h234;
    logic          aclk = 1'b0;
    logic          aresetn = 1'b0;
    logic [11:0]   awaddr = 12'h000, araddr = 12'h000;
    logic [31:0]   wdata = 32'h00000000;
    logic [3:0]    wstrb = 4'h1;
    logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic          arvalid = 1'b0, rready = 1'b0;
    logic [7:0]    req = 8'h00;
    logic          rx_lvl = 1'b0, tx_lvl = 1'b0;
    pif_ccp_mode_t capcmp_one_mode = PIF_MODE_CAPTURE;
    pif_ccp_mode_t capcmp_two_mode = PIF_MODE_CAPTURE;
    logic          awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]    bresp, rresp, wr_resp, rd_resp;
    logic [31:0]   rdata, v;
    logic          sync_serial_done, capcmp_one_event, period_timer_match;
    logic          wide_timer_overflow, serial_receive_full;
    logic          serial_transmit_empty, parallel_port_done;
    logic          capcmp_two_event;
    int            miscompares = 0, n_checks = 0, cyc = 0, m;

    pif_top uut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .sync_serial_done, .capcmp_one_event,
        .capcmp_one_mode, .period_timer_match, .wide_timer_overflow,
        .serial_receive_full, .serial_transmit_empty, .parallel_port_done,
        .capcmp_two_event, .capcmp_two_mode, .irq);

    pif_periph_model peri (.aclk, .aresetn, .req, .rx_lvl, .tx_lvl,
        .sync_serial_done, .capcmp_one_event, .period_timer_match,
        .wide_timer_overflow, .serial_receive_full, .serial_transmit_empty,
        .parallel_port_done, .capcmp_two_event);

    initial begin
        forever #20 aclk = ~aclk;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // The event mask goes out with the request, so it lands at the commit.
    task automatic axi_write(input logic [11:0] a, input logic [7:0] d,
                             input logic [3:0] s, input logic [7:0] ev);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        req     <= ev;
        do begin
            @(posedge aclk);
            req <= 8'h00;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        wr_resp = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
    endtask : axi_read

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        axi_read(a);
        check(v, e);
        check({30'h0, rd_resp}, 32'h0);
    endtask : rd_chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        axi_write(a, d, 4'h1, 8'h00);
    endtask : wr

    task automatic fire(input logic [7:0] ev);
        @(posedge aclk);
        req <= ev;
        @(posedge aclk);
        req <= 8'h00;
        repeat (3) @(posedge aclk);
    endtask : fire

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(adr_ctl, 32'h0);
        rd_chk(adr_fl1, 32'h0);
        rd_chk(adr_fl2, 32'h0);
        rd_chk(adr_en1, 32'h0);
        rd_chk(adr_en2, 32'h0);
        axi_read(12'h100);
        check(v, 32'h0);
        check({30'h0, rd_resp}, 32'h2);
        wr(12'h100, 8'hff);
        check({30'h0, wr_resp}, 32'h2);
        // Every pulsed source of flag register one fires with all enables off.
        fire(8'h8f);
        rd_chk(adr_fl1, 32'h8f);
        check({31'h0, irq}, 32'h0);
        wr(adr_fl1, 8'h00);
        rd_chk(adr_fl1, 32'h0);
        for (m = 0; m < 4; m++) begin
            capcmp_one_mode <= pif_ccp_mode_t'(m[1:0]);
            capcmp_two_mode <= pif_ccp_mode_t'(m[1:0]);
            fire(8'h44);
            rd_chk(adr_fl1, (m < 2) ? 32'h4 : 32'h0);
            rd_chk(adr_fl2, (m < 2) ? 32'h1 : 32'h0);
            wr(adr_fl1, 8'h00);
            wr(adr_fl2, 8'h00);
        end
        capcmp_one_mode <= PIF_MODE_CAPTURE;
        capcmp_two_mode <= PIF_MODE_CAPTURE;
        rx_lvl <= 1'b1;
        repeat (3) @(posedge aclk);
        rd_chk(adr_fl1, 32'h20);
        wr(adr_fl1, 8'h00);
        rd_chk(adr_fl1, 32'h20);
        rx_lvl <= 1'b0;
        tx_lvl <= 1'b1;
        repeat (3) @(posedge aclk);
        wr(adr_fl1, 8'h20);
        rd_chk(adr_fl1, 32'h10);
        tx_lvl <= 1'b0;
        repeat (3) @(posedge aclk);
        rd_chk(adr_fl1, 32'h0);
        wr(adr_en1, 8'hbf);
        check({30'h0, wr_resp}, 32'h0);
        rd_chk(adr_en1, 32'hbf);
        wr(adr_en2, 8'hff);
        rd_chk(adr_en2, 32'h1);
        axi_write(adr_en2, 8'h00, 4'h0, 8'h00);
        rd_chk(adr_en2, 32'h1);
        fire(8'h01);
        check({31'h0, irq}, 32'h0);
        wr(adr_ctl, 8'h80);
        repeat (2) @(posedge aclk);
        check({31'h0, irq}, 32'h1);
        wr(adr_fl1, 8'h00);
        repeat (2) @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        wr(adr_en1, 8'h00);
        fire(8'h40);
        check({31'h0, irq}, 32'h1);
        wr(adr_en2, 8'h00);
        repeat (2) @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        rd_chk(adr_fl2, 32'h1);
        // An overflow lands on the same edge as a clearing write.
        axi_write(adr_fl1, 8'h00, 4'h1, 8'h01);
        rd_chk(adr_fl1, 32'h1);
        print_verdict();
    end
endmodule : tb_top
